// *** bench/nand_ecc_result_registers_tb_top.sv ***
// Self-checking bench for the result registers against a behavioural model.
// Assumes the engine model drives the engine inputs; the bench is APB master.
`timescale 1ns/100ps
module nand_ecc_result_registers_tb_top
   import ner_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [2:0] ctype = TYPE_H256;
   logic four_en = 1'b0;
   logic page_read = 1'b0;
   logic e_bv, e_se, e_we, e_re, e_done;
   logic [7:0] e_b;
   logic [3:0] e_si;
   logic [11:0] e_ref;
   logic [2:0] e_sub;
   logic [79:0] e_sym;
   logic [39:0] e_pat;
   int bad_count = 0;
   int check_count = 0;
   int seed = 32'h53AB0012;
   int m_par[16];
   int m_loc[16];
   logic [7:0] m_cw[CW_COUNT];
   logic [9:0] m_mask[MASK_COUNT];
   logic [2:0] m_stat = 3'h0;
   logic [2:0] m_imask = 3'h0;

   always #50 clk_sys_in = ~clk_sys_in;

   ner_result_regs u_ner_result_regs (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .correction_type_select_in(ctype), .four_error_correction_enable_in(four_en),
      .page_read_in(page_read), .ecc_byte_valid_in(e_bv), .ecc_byte_in(e_b),
      .ecc_sector_end_in(e_se), .ecc_sector_index_in(e_si), .ecc_ref_parity_in(e_ref),
      .rs_write_end_in(e_we), .rs_read_end_in(e_re), .rs_subpage_in(e_sub),
      .rs_symbols_in(e_sym), .correction_done_in(e_done), .correction_pattern_in(e_pat),
      .irq_out(irq));
   ner_engine_model u_ner_engine_model (.clk_sys_in(clk_sys_in), .byte_valid_out(e_bv),
      .byte_out(e_b), .sector_end_out(e_se), .sector_index_out(e_si),
      .ref_parity_out(e_ref), .wr_end_out(e_we), .rd_end_out(e_re), .subpage_out(e_sub),
      .symbols_out(e_sym), .done_out(e_done), .pattern_out(e_pat));

   // ----
   // Model and checks
   // ----
   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   function automatic int ham(input logic [7:0] q[$]);
      int p;
      p = 0;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            if (q[i][b])
               p ^= i * 8 + b;
      return p;
   endfunction : ham
   // Returns {slave error, read data}
   function automatic logic [32:0] exp_rd(input logic [11:0] a);
      int n;
      int c;
      n = a / 4 - SPL_BASE / 4 + SPL_FIRST;
      c = a / 4 - CW_BASE / 4;
      if (n >= SPL_FIRST && n < 16)
      begin
         if (ctype == TYPE_H256)
            return {10'h000, m_par[n][10:0], 1'b0, m_loc[n][10:0]};
         if (ctype == TYPE_H512 && n <= SPL_LAST_512)
            return {9'h000, m_par[n][11:0], m_loc[n][11:0]};
         return 33'h0;
      end
      if (c >= 0 && c < CW_COUNT)
         return {25'h0, m_cw[c]};
      if (c >= CW_COUNT && c < CW_COUNT + MASK_COUNT)
         return {23'h0, m_mask[c - CW_COUNT]};
      if (a == IRQ_MASK_ADDR)
         return {30'h0, m_imask};
      if (a == IRQ_STATUS_ADDR)
         return {30'h0, m_stat};
      return {1'b1, 32'h0};
   endfunction : exp_rd

   // ----
   // APB master
   // ----
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk_sys_in);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge clk_sys_in);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         chk(33'h0, 33'h1, "no ready");
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   task automatic rd_chk(input logic [11:0] a);
      logic [32:0] e;
      logic [31:0] d;
      logic er;
      e = exp_rd(a);
      apb(1'b0, a, 32'h0, d, er);
      chk({er, d}, e, $sformatf("read %h", a));
   endtask : rd_chk
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] wd);
      logic [32:0] e;
      logic [31:0] d;
      logic er;
      e = exp_rd(a);
      apb(1'b1, a, wd, d, er);
      chk({32'h0, er}, {32'h0, e[32]}, "write error");
      if (a == IRQ_MASK_ADDR)
         m_imask = wd[2:0];
      if (a == IRQ_STATUS_ADDR)
         m_stat = m_stat & ~wd[2:0];
   endtask : wr_chk
   task automatic ham_case(input logic [2:0] t, input int idx, input int nb);
      logic [7:0] q[$];
      logic [31:0] d;
      logic er;
      logic [11:0] spare;
      logic [11:0] a;
      int pos;
      ctype <= t;
      page_read <= 1'b0;
      a = SPL_BASE + 12'(4 * (idx - SPL_FIRST));
      for (int i = 0; i < nb; i++)
         q.push_back(8'($random(seed)));
      u_ner_engine_model.send_sector(q, 4'(idx), 12'($random(seed)));
      m_par[idx] = ham(q);
      m_loc[idx] = 0;
      m_stat[IRQ_SECTOR_BIT] = 1'b1;
      rd_chk(a);
      wr_chk(a, 32'hFFFFFFFF);
      apb(1'b0, a, 32'h0, d, er);
      spare = (t == TYPE_H256) ? {1'b0, d[22:12]} : d[23:12];
      pos = {$random(seed)} % (nb * 8);
      q[pos / 8][pos % 8] = ~q[pos / 8][pos % 8];
      page_read <= 1'b1;
      u_ner_engine_model.send_sector(q, 4'(idx), spare);
      m_par[idx] = ham(q);
      m_loc[idx] = pos;
      rd_chk(a);
   endtask : ham_case

   initial
   begin
      // Tests need about 2000 cycles; allow fifteen times that
      #3000000;
      bad_count++;
      close_out();
   end

   initial
   begin
      logic [79:0] sym;
      logic [39:0] pat;
      logic [31:0] d;
      logic er;
      logic [11:0] probe [10];
      foreach (m_par[i])
         {m_par[i], m_loc[i]} = 64'h0;
      foreach (m_cw[i])
         m_cw[i] = 8'h00;
      foreach (m_mask[i])
         m_mask[i] = 10'h000;
      repeat (8) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      probe = '{12'h018, 12'h04C, 12'h050, 12'h18C, 12'h190, 12'h19C, IRQ_MASK_ADDR,
         IRQ_STATUS_ADDR, 12'h1A0, 12'h1F0};
      foreach (probe[i])
         rd_chk(probe[i]);
      $display("test reset done");
      ham_case(TYPE_H256, 3, 256);
      $display("test hamming 256 done");
      ham_case(TYPE_H512, 7, 300);
      u_ner_engine_model.send_sector({8'hFF, 8'h5A}, 4'h8, 12'h000);
      rd_chk(12'h030);
      ctype <= TYPE_H256;
      @(posedge clk_sys_in);
      rd_chk(12'h030);
      $display("test hamming 512 done");
      sym = {$random(seed), $random(seed), $random(seed)};
      u_ner_engine_model.rs_load(1'b0, 3'h1, sym);
      rd_chk(12'h078);
      ctype <= 3'h4 | 3'($random(seed) & 3);
      u_ner_engine_model.send_sector({8'h81}, 4'h2, 12'h000);
      rd_chk(12'h01C);
      for (int r = 0; r < 2; r++)
      begin
         sym = {$random(seed), $random(seed), $random(seed)};
         u_ner_engine_model.rs_load(r[0], r[0] ? 3'h0 : 3'h7, sym);
         for (int j = 0; j < CW_PER_SUBPAGE; j++)
            m_cw[(r == 0 ? 70 : 0) + j] = sym[8 * j +: 8];
         m_stat[IRQ_RS_BIT] = 1'b1;
      end
      for (int i = 0; i < CW_COUNT; i++)
         rd_chk(CW_BASE + 12'(4 * i));
      wr_chk(12'h064, 32'h000000A5);
      rd_chk(12'h064);
      $display("test codeword done");
      pat = {$random(seed), $random(seed)};
      for (int r = 0; r < 2; r++)
      begin
         four_en <= r[0];
         u_ner_engine_model.finish_corr(pat);
         m_stat[IRQ_DONE_BIT] = 1'b1;
         for (int k = 0; k < MASK_COUNT; k++)
         begin
            m_mask[k] = r[0] ? pat[10 * k +: 10] : m_mask[k];
            rd_chk(MASK_BASE + 12'(4 * k));
         end
      end
      apb(1'b0, MASK_BASE, 32'h0, d, er);
      chk({23'h0, d[9:0] ^ 10'h3FF}, {23'h0, pat[9:0] ^ 10'h3FF}, "fix");
      wr_chk(MASK_BASE + 12'h004, 32'hFFFFFFFF);
      rd_chk(MASK_BASE + 12'h004);
      $display("test mask done");
      wr_chk(IRQ_MASK_ADDR, 32'hFFFFFFF9);
      rd_chk(IRQ_STATUS_ADDR);
      chk({32'h0, irq}, {32'h0, |(m_stat & m_imask)}, "irq masked");
      for (int r = 0; r < 2; r++)
      begin
         wr_chk(r[0] ? IRQ_STATUS_ADDR : IRQ_MASK_ADDR, r[0] ? 32'h7 : 32'h7);
         rd_chk(IRQ_STATUS_ADDR);
         chk({32'h0, irq}, {32'h0, |(m_stat & m_imask)}, "irq level");
      end
      $display("test interrupt done");
      close_out();
   end
endmodule : nand_ecc_result_registers_tb_top

// *** bench/ner_engine_model.sv ***
// Correction engine model feeding the result registers.
// Assumes the bench clock; each task starts at the next rising edge.
`timescale 1ns/100ps
module ner_engine_model
(
   input wire logic clk_sys_in,
   output logic byte_valid_out,
   output logic [7:0] byte_out,
   output logic sector_end_out,
   output logic [3:0] sector_index_out,
   output logic [11:0] ref_parity_out,
   output logic wr_end_out,
   output logic rd_end_out,
   output logic [2:0] subpage_out,
   output logic [79:0] symbols_out,
   output logic done_out,
   output logic [39:0] pattern_out
);
   initial
   begin
      {byte_valid_out, sector_end_out, wr_end_out, rd_end_out, done_out} = 5'h00;
      {byte_out, sector_index_out, ref_parity_out, subpage_out} = 27'h0000000;
      {symbols_out, pattern_out} = 120'h0;
   end
   task automatic send_sector(input logic [7:0] q[$], input logic [3:0] idx,
      input logic [11:0] refp);
      foreach (q[i])
      begin
         @(posedge clk_sys_in);
         byte_valid_out <= 1'b1;
         byte_out <= q[i];
      end
      @(posedge clk_sys_in);
      byte_valid_out <= 1'b0;
      // Idle data is inverted so a stale byte never looks valid
      byte_out <= ~byte_out;
      sector_end_out <= 1'b1;
      sector_index_out <= idx;
      ref_parity_out <= refp;
      @(posedge clk_sys_in);
      sector_end_out <= 1'b0;
      ref_parity_out <= ~refp;
   endtask : send_sector
   task automatic rs_load(input logic rd, input logic [2:0] sub, input logic [79:0] sym);
      @(posedge clk_sys_in);
      wr_end_out <= ~rd;
      rd_end_out <= rd;
      subpage_out <= sub;
      symbols_out <= sym;
      @(posedge clk_sys_in);
      {wr_end_out, rd_end_out} <= 2'h0;
      symbols_out <= ~sym;
   endtask : rs_load
   task automatic finish_corr(input logic [39:0] pat);
      @(posedge clk_sys_in);
      done_out <= 1'b1;
      pattern_out <= pat;
      @(posedge clk_sys_in);
      done_out <= 1'b0;
      pattern_out <= ~pat;
   endtask : finish_corr
endmodule : ner_engine_model

// *** hw/ner_acc_if.sv ***
// Link between the result registers and the sector parity accumulator.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface ner_acc_if;
   logic clr;
   logic byte_valid;
   logic [7:0] byte_data;
   logic sector512;
   logic [11:0] parity;
   modport ctrl (output clr, output byte_valid, output byte_data, output sector512,
                 input parity);
   modport acc (input clr, input byte_valid, input byte_data, input sector512,
                output parity);
endinterface : ner_acc_if

// *** hw/ner_hamming_acc.sv ***
// Sector parity accumulator: XOR of the positions of all one bits.
// Assumes clr and byte_valid are never high in the same cycle.
`timescale 1ns/100ps
module ner_hamming_acc
   import ner_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   ner_acc_if.acc acc_if
);
   ner_acc_state_type s;
   ner_acc_state_type next_s;
   logic [PAR_WIDTH-1:0] chain [0:8];

   // ---------------------------------------------------------------
   // Per-bit position terms
   // ---------------------------------------------------------------
   assign chain[0] = s.parity;
   for (genvar i = 0; i < 8; i++)
   begin : g_bit
      logic [PAR_WIDTH-1:0] pos;
      // Byte address narrows to 8 bits for 256-byte sectors
      assign pos = acc_if.sector512 ? {s.count, 3'(i)} : {1'b0, s.count[7:0], 3'(i)};
      assign chain[i+1] = chain[i] ^ (pos & {PAR_WIDTH{acc_if.byte_data[i]}});
   end

   always_comb
   begin
      next_s = s;
      if (acc_if.clr)
      begin
         next_s = '0;
      end
      else if (acc_if.byte_valid)
      begin
         next_s.parity = chain[8];
         next_s.count = 9'(s.count + 9'h001);
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
         s <= '0;
      else
         s <= next_s;
   end

   assign acc_if.parity = s.parity;

   property p_clr_zero;
      @(posedge clk_sys_in) disable iff (!resetn_in)
      acc_if.clr |=> (s.parity == '0) && (s.count == '0);
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("parity not cleared");
endmodule : ner_hamming_acc

// *** hw/ner_pkg.sv ***
// Constants and types for the NAND ECC result registers.
// Assumes a 32-bit APB slave with byte addresses in a 4 KB window.
package ner_pkg;
   // ---------------------------------------------------------------
   // Register map, byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] SPL_BASE = 12'h018;
   localparam logic [11:0] CW_BASE = 12'h050;
   localparam logic [11:0] MASK_BASE = 12'h190;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h1C4;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h1C8;
   // ---------------------------------------------------------------
   // Sizes and field layout
   // ---------------------------------------------------------------
   localparam int SPL_FIRST = 2;
   localparam int SPL_COUNT = 14;
   localparam int SPL_LAST_512 = 7;
   localparam int CW_COUNT = 80;
   localparam int CW_PER_SUBPAGE = 10;
   localparam int MASK_COUNT = 4;
   localparam int MASK_WIDTH = 10;
   localparam int PAR_WIDTH = 12;
   localparam int IRQ_WIDTH = 3;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_SECTOR_BIT = 1;
   localparam int IRQ_RS_BIT = 2;
   // ---------------------------------------------------------------
   // Correction type codes and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] TYPE_H256 = 3'h1;
   localparam logic [2:0] TYPE_H512 = 3'h2;
   localparam int TYPE_RS_BIT = 2;
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

   typedef struct packed {
      logic [8:0] count;
      logic [PAR_WIDTH-1:0] parity;
   } ner_acc_state_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [CW_COUNT-1:0][7:0] cw;
      logic [MASK_COUNT-1:0][MASK_WIDTH-1:0] mask;
      logic [SPL_COUNT-1:0][PAR_WIDTH-1:0] parity;
      logic [SPL_COUNT-1:0][PAR_WIDTH-1:0] loc;
   } ner_state_type;
endpackage : ner_pkg

// *** hw/ner_result_regs.sv ***
// NAND ECC result registers behind an APB slave.
// Assumes the correction engine drives the load inputs on clk_sys_in.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module ner_result_regs
   import ner_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [11:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [2:0] correction_type_select_in,
   input wire logic four_error_correction_enable_in,
   input wire logic page_read_in,
   input wire logic ecc_byte_valid_in,
   input wire logic [7:0] ecc_byte_in,
   input wire logic ecc_sector_end_in,
   input wire logic [3:0] ecc_sector_index_in,
   input wire logic [11:0] ecc_ref_parity_in,
   input wire logic rs_write_end_in,
   input wire logic rs_read_end_in,
   input wire logic [2:0] rs_subpage_in,
   input wire logic [79:0] rs_symbols_in,
   input wire logic correction_done_in,
   input wire logic [39:0] correction_pattern_in,
   output logic irq_out
);
   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   localparam logic [9:0] SPL_W0 = SPL_BASE[11:2];
   localparam logic [9:0] CW_W0 = CW_BASE[11:2];
   localparam logic [9:0] MASK_W0 = MASK_BASE[11:2];
   localparam logic [9:0] IRQ_MASK_W = IRQ_MASK_ADDR[11:2];
   localparam logic [9:0] IRQ_STATUS_W = IRQ_STATUS_ADDR[11:2];

   ner_state_type s;
   ner_state_type next_s;
   ner_acc_if acc_if ();

   logic [9:0] word;
   logic [9:0] spl_off;
   logic [9:0] cw_off;
   logic [9:0] mask_off;
   logic [3:0] spl_slot;
   logic [6:0] cw_idx;
   logic [1:0] mask_idx;
   logic [3:0] sec_slot;
   logic mode_256;
   logic mode_512;
   logic mode_rs;
   logic access;
   logic wr_take;
   logic ham_take;
   logic rs_take;
   logic [6:0] sub_base;
   logic [PAR_WIDTH-1:0] calc_par;
   logic [31:0] rd_data;
   logic hit;

   assign word = paddr_in[11:2];
   assign spl_off = 10'(word - SPL_W0);
   assign cw_off = 10'(word - CW_W0);
   assign mask_off = 10'(word - MASK_W0);
   assign spl_slot = spl_off[3:0];
   assign cw_idx = cw_off[6:0];
   assign mask_idx = mask_off[1:0];
   assign mode_rs = correction_type_select_in[TYPE_RS_BIT];
   assign mode_256 = (correction_type_select_in == TYPE_H256);
   assign mode_512 = (correction_type_select_in == TYPE_H512);
   assign access = psel_in & penable_in & ~s.pready;
   assign wr_take = psel_in & penable_in & s.pready & pwrite_in;
   assign sec_slot = 4'(ecc_sector_index_in - 4'(SPL_FIRST));
   // Sectors 0 and 1 live outside this block
   assign ham_take = ecc_sector_end_in & (mode_256 | mode_512) &
                     (ecc_sector_index_in >= 4'(SPL_FIRST)) &
                     (mode_256 | (ecc_sector_index_in <= 4'(SPL_LAST_512)));
   assign rs_take = mode_rs & (rs_write_end_in | rs_read_end_in);
   assign sub_base = 7'(rs_subpage_in * 7'(CW_PER_SUBPAGE));

   // ---------------------------------------------------------------
   // Parity accumulator
   // ---------------------------------------------------------------
   assign acc_if.clr = ecc_sector_end_in;
   assign acc_if.byte_valid = ecc_byte_valid_in & ~mode_rs;
   assign acc_if.byte_data = ecc_byte_in;
   assign acc_if.sector512 = mode_512;
   assign calc_par = mode_256 ? {1'b0, acc_if.parity[10:0]} : acc_if.parity;

   ner_hamming_acc u_acc (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .acc_if(acc_if)
   );

   // ---------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_data = REG_RESET;
      hit = 1'b0;
      if ((word >= SPL_W0) && (spl_off < 10'(SPL_COUNT)))
      begin
         hit = 1'b1;
         if (mode_256)
            rd_data = {9'h000, s.parity[spl_slot][10:0], 1'b0, s.loc[spl_slot][10:0]};
         else if (mode_512 && (spl_slot <= 4'(SPL_LAST_512 - SPL_FIRST)))
            rd_data = {8'h00, s.parity[spl_slot], s.loc[spl_slot]};
      end
      else if ((word >= CW_W0) && (cw_off < 10'(CW_COUNT)))
      begin
         hit = 1'b1;
         rd_data = {24'h000000, s.cw[cw_idx]};
      end
      else if ((word >= MASK_W0) && (mask_off < 10'(MASK_COUNT)))
      begin
         hit = 1'b1;
         rd_data = {22'h000000, s.mask[mask_idx]};
      end
      else if (word == IRQ_MASK_W)
      begin
         hit = 1'b1;
         rd_data = {29'h00000000, s.irq_mask};
      end
      else if (word == IRQ_STATUS_W)
      begin
         hit = 1'b1;
         rd_data = {29'h00000000, s.irq_status};
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [IRQ_WIDTH-1:0] set_bits;
      logic [IRQ_WIDTH-1:0] clr_bits;
      set_bits = '0;
      clr_bits = '0;
      next_s = s;
      // One wait state: pready rises in the second access cycle
      next_s.pready = access;
      next_s.pslverr = access & ~hit;
      if (access && !pwrite_in)
         next_s.prdata = rd_data;
      // Result registers ignore writes; only the interrupt mask and status take them
      if (wr_take && (word == IRQ_MASK_W))
         next_s.irq_mask = pwdata_in[IRQ_WIDTH-1:0];
      if (wr_take && (word == IRQ_STATUS_W))
         clr_bits = pwdata_in[IRQ_WIDTH-1:0];
      if (ham_take)
      begin
         next_s.parity[sec_slot] = calc_par;
         // On a page read the locator is the XOR of stored and recomputed parity; otherwise it is zero
         if (page_read_in)
            next_s.loc[sec_slot] = calc_par ^ ecc_ref_parity_in;
         else
            next_s.loc[sec_slot] = '0;
         set_bits[IRQ_SECTOR_BIT] = 1'b1;
      end
      if (rs_take)
      begin
         for (int j = 0; j < CW_PER_SUBPAGE; j++)
         begin
            // Symbols arrive packed as 80 bits; cut into bytes
            next_s.cw[7'(sub_base + 7'(j))] = rs_symbols_in[8*j +: 8];
         end
         set_bits[IRQ_RS_BIT] = 1'b1;
      end
      if (correction_done_in)
      begin
         // Masks carry meaning only with four-error correction on
         if (four_error_correction_enable_in && mode_rs)
         begin
            for (int k = 0; k < MASK_COUNT; k++)
            begin
               next_s.mask[k] = correction_pattern_in[MASK_WIDTH*k +: MASK_WIDTH];
            end
         end
         set_bits[IRQ_DONE_BIT] = 1'b1;
      end
      // A new event wins over a clear in the same cycle
      next_s.irq_status = (s.irq_status & ~clr_bits) | set_bits;
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         s <= '0;
         s.irq_status <= IRQ_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata_out = s.prdata;
   assign pready_out = s.pready;
   assign pslverr_out = s.pslverr;
   assign irq_out = s.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   property p_spl256_layout;
      access && !pwrite_in && hit && mode_256 && (word < CW_W0)
      |=> (prdata_out[31:23] == 9'h000) && (prdata_out[11] == 1'b0);
   endproperty
   a_spl256_layout: assert property (p_spl256_layout) else $error("256 layout bad");

   property p_spl512_layout;
      access && !pwrite_in && hit && mode_512 && (word < CW_W0)
      |=> prdata_out[31:24] == 8'h00;
   endproperty
   a_spl512_layout: assert property (p_spl512_layout) else $error("512 layout bad");

   property p_spl512_absent;
      access && !pwrite_in && mode_512 && (word >= SPL_W0) &&
      (spl_off > 10'(SPL_LAST_512 - SPL_FIRST)) && (spl_off < 10'(SPL_COUNT))
      |=> prdata_out == 32'h00000000;
   endproperty
   a_spl512_absent: assert property (p_spl512_absent) else $error("absent word not zero");

   property p_locator;
      ham_take && page_read_in
      |=> s.loc[$past(sec_slot)] == $past(calc_par ^ ecc_ref_parity_in);
   endproperty
   a_locator: assert property (p_locator) else $error("locator wrong");

   property p_cw_upper_zero;
      access && !pwrite_in && (word >= CW_W0) && (cw_off < 10'(CW_COUNT))
      |=> prdata_out[31:8] == 24'h000000 ##1 !pready_out;
   endproperty
   a_cw_upper_zero: assert property (p_cw_upper_zero) else $error("codeword upper bits");

   property p_cw_split;
      rs_take && (rs_subpage_in == 3'h7)
      |=> (s.cw[70] == $past(rs_symbols_in[7:0])) && (s.cw[79] == $past(rs_symbols_in[79:72]));
   endproperty
   a_cw_split: assert property (p_cw_split) else $error("codeword split wrong");

   property p_rs_gated;
      (rs_write_end_in || rs_read_end_in) && !mode_rs |=> $stable(s.cw);
   endproperty
   a_rs_gated: assert property (p_rs_gated) else $error("codeword loaded in Hamming");

   property p_mask_width;
      access && !pwrite_in && (word >= MASK_W0) && (mask_off < 10'(MASK_COUNT))
      |=> prdata_out[31:10] == 22'h000000;
   endproperty
   a_mask_width: assert property (p_mask_width) else $error("mask upper bits");

   property p_mask_gated;
      correction_done_in && !four_error_correction_enable_in |=> $stable(s.mask);
   endproperty
   a_mask_gated: assert property (p_mask_gated) else $error("mask loaded while off");

   property p_done_flag;
      correction_done_in |=> s.irq_status[IRQ_DONE_BIT] ##1 (s.irq_status[IRQ_DONE_BIT] ||
         $past(wr_take && (word == IRQ_STATUS_W) && pwdata_in[IRQ_DONE_BIT]));
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag missing");

   property p_ro_write;
      wr_take && (word >= CW_W0) && (cw_off < 10'(CW_COUNT)) && !rs_take |=> $stable(s.cw);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only written");

   property p_ro_par_write;
      wr_take && (word >= SPL_W0) && (spl_off < 10'(SPL_COUNT)) && !ham_take
      |=> $stable(s.parity) && $stable(s.loc);
   endproperty
   a_ro_par_write: assert property (p_ro_par_write) else $error("parity written");

   property p_ro_mask_write;
      wr_take && (word >= MASK_W0) && (mask_off < 10'(MASK_COUNT)) && !correction_done_in
      |=> $stable(s.mask);
   endproperty
   a_ro_mask_write: assert property (p_ro_mask_write) else $error("mask written");

   property p_unmapped;
      access && !hit |=> pslverr_out && pready_out;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no slave error");

   property p_loc_on_write;
      ham_take && !page_read_in |=> s.loc[$past(sec_slot)] == '0;
   endproperty
   a_loc_on_write: assert property (p_loc_on_write) else $error("locator not zero");

   property p_sector_flag;
      ham_take |=> s.irq_status[IRQ_SECTOR_BIT];
   endproperty
   a_sector_flag: assert property (p_sector_flag) else $error("sector flag missing");

   property p_rs_flag;
      rs_take |=> s.irq_status[IRQ_RS_BIT];
   endproperty
   a_rs_flag: assert property (p_rs_flag) else $error("codeword flag missing");

   property p_mask_load;
      correction_done_in && four_error_correction_enable_in && mode_rs
      |=> s.mask[0] == $past(correction_pattern_in[MASK_WIDTH-1:0]);
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

   c_cw_read: cover property (access && !pwrite_in && (word >= CW_W0) && (cw_off < 10'(CW_COUNT)));
   c_mask_load: cover property (correction_done_in && four_error_correction_enable_in && mode_rs);
   c_irq: cover property ($rose(irq_out));
   c_err: cover property (pslverr_out && pready_out);
endmodule : ner_result_regs
